//--- panel_sel_params.svh
`ifndef PANEL_SEL_PARAMS_SVH
`define PANEL_SEL_PARAMS_SVH
// ***************************************************
// register map (byte addresses on the apb bus)
// ***************************************************
`define REG_CTRL 12'h000
`define REG_ACTIVE 12'h004
`define REG_MEAS 12'h008
`define REG_STATUS 12'h00c
// ***************************************************
// control register fields and reset values
// ***************************************************
`define CTRL_W 12
`define CTRL_RESET 12'h000
`define ACTIVE_RESET 32'hffff_ffff
`define CTL_CFG32 0
`define CTL_REC_MODE 1
`define CTL_CAL_MODE 2
`define CTL_MON_ROUTE 3
`define CTL_REC_BUS 4
`define CTL_METER_OK 5
`define CTL_SOURCE_OK 6
`define CTL_STIM_OK 7
`define CTL_FM_BUS 8
`define CTL_DIR_BUS 9
`define CTL_PRE_TOP 10
`define CTL_TEST_FAIL 11
// ***************************************************
// pushbutton indices
// ***************************************************
`define NUM_BTN 8
`define BTN_UP 0
`define BTN_DOWN 1
`define BTN_CARD 2
`define BTN_RIGHT 3
`define BTN_LEFT 4
`define BTN_SOURCE 5
`define BTN_STIM 6
`define BTN_TEST 7
// ***************************************************
// timing: times in ns, counts derived from the clock
// ***************************************************
`define CLK_PERIOD_NS 10
`define DEBOUNCE_NS 10000000
`define REPEAT_NS 250000000
`define BLINK_NS 500000000
`define DEBOUNCE_CYC (`DEBOUNCE_NS / `CLK_PERIOD_NS)
`define REPEAT_CYC (`REPEAT_NS / `CLK_PERIOD_NS)
`define BLINK_CYC (`BLINK_NS / `CLK_PERIOD_NS)
`endif

//--- panel_sel_pkg.sv
package panel_sel_pkg;
  // data card type as sensed on the card-type lines
  typedef enum logic [1:0] {
    CARD_DIRECT,
    CARD_MEDIUM,
    CARD_WIDE,
    CARD_EMPTY
  } card_code_t;
  // meter functions in left-to-right panel order
  typedef enum logic [2:0] {
    FN_FREQ,
    FN_DC,
    FN_PEAK,
    FN_RMS,
    FN_DIST
  } meter_fn_t;
endpackage

//--- panel_chan_meter_cal.sv
`timescale 1ns/1ps
`include "panel_sel_params.svh"
module panel_chan_meter_cal #(
  parameter int unsigned DEB_CYCLES = `DEBOUNCE_CYC,
  parameter int unsigned RPT_CYCLES = `REPEAT_CYC,
  parameter int unsigned BLINK_CYCLES = `BLINK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclken,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`NUM_BTN-1:0] buttons,
  input wire logic meter_source_switch,
  input wire panel_sel_pkg::card_code_t rec_card_type,
  input wire panel_sel_pkg::card_code_t play_card_type,
  output logic [7:0] channel_digits,
  output logic [23:0] meas_digits,
  output logic direct_card_lamp,
  output logic medium_band_card_lamp,
  output logic wide_band_card_lamp,
  output logic monitor_path_lamp,
  output logic monitor_card_sel,
  output logic play_bus_lamp,
  output logic record_bus_lamp,
  output logic bypass_bus_sel,
  output logic frequency_function_lamp,
  output logic dc_function_lamp,
  output logic peak_function_lamp,
  output logic rms_function_lamp,
  output logic distortion_function_lamp,
  output logic internal_source_lamp,
  output logic external_source_lamp,
  output logic stimulus_pos0_lamp,
  output logic stimulus_pos1_lamp,
  output logic stimulus_pos2_lamp,
  output logic stimulus_pos3_lamp,
  output logic [2:0] stimulus_select,
  output logic stimulus_dc_level,
  output logic direct_bus_lamp,
  output logic fm_bus_lamp,
  output logic cal_lamp,
  output logic autotest_lamp
);
  import panel_sel_pkg::*;

  // ***************************************************
  // pushbutton debounce and press detection
  // ***************************************************
  logic [`NUM_BTN-1:0] btn_level; // debounced level per button
  logic [`NUM_BTN-1:0] btn_press; // one-cycle pulse per press

  for (genvar gi = 0; gi < `NUM_BTN; gi++) begin : g_btn
    logic [31:0] cnt_q; // cycles the raw input differed
    logic stable_q; // accepted level
    logic prev_q; // accepted level one cycle ago
    // a change is taken only after it holds for the full time
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_q <= 32'h0000_0000;
        stable_q <= 1'b0;
        prev_q <= 1'b0;
      end else if (pclken) begin
        prev_q <= stable_q;
        if (buttons[gi] == stable_q) begin
          cnt_q <= 32'h0000_0000;
        end else if (cnt_q >= 32'(DEB_CYCLES - 1)) begin
          cnt_q <= 32'h0000_0000;
          stable_q <= buttons[gi];
        end else begin
          cnt_q <= cnt_q + 32'h0000_0001;
        end
      end
    end
    assign btn_level[gi] = stable_q;
    assign btn_press[gi] = stable_q & ~prev_q;
  end

  // ***************************************************
  // auto-repeat for held channel buttons
  // ***************************************************
  logic [31:0] rpt_cnt_q; // time since last step while held
  wire chan_held = btn_level[`BTN_UP] | btn_level[`BTN_DOWN];
  wire rpt_fire = chan_held && (rpt_cnt_q >= 32'(RPT_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpt_cnt_q <= 32'h0000_0000;
    end else if (pclken) begin
      // restart on release or on each step
      if (!chan_held || rpt_fire || btn_press[`BTN_UP] || btn_press[`BTN_DOWN]) begin
        rpt_cnt_q <= 32'h0000_0000;
      end else begin
        rpt_cnt_q <= rpt_cnt_q + 32'h0000_0001;
      end
    end
  end

  // up wins if both are held; avoids a zero-net step
  wire step_up = btn_press[`BTN_UP] | (rpt_fire & btn_level[`BTN_UP]);
  wire step_dn = ~step_up & (btn_press[`BTN_DOWN] | (rpt_fire & btn_level[`BTN_DOWN]));

  // ***************************************************
  // shared blink clock
  // ***************************************************
  logic [31:0] blink_cnt_q; // cycles in current blink half
  logic blink_q; // blink phase, shared by the card, function, direct bus and cal lamps

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b1;
    end else if (pclken) begin
      if (blink_cnt_q >= 32'(BLINK_CYCLES - 1)) begin
        blink_cnt_q <= 32'h0000_0000;
        blink_q <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
      end
    end
  end

  // ***************************************************
  // apb register file
  // ***************************************************
  logic [`CTRL_W-1:0] ctrl_q; // mode and permission bits
  logic [31:0] active_q; // one bit per fitted channel
  logic [23:0] meas_q; // six bcd digits from the meter
  logic [31:0] prdata_q; // read data, caught in setup
  logic [31:0] status_w; // live state for software

  wire hit_ctrl = paddr == `REG_CTRL;
  wire hit_active = paddr == `REG_ACTIVE;
  wire hit_meas = paddr == `REG_MEAS;
  wire hit_status = paddr == `REG_STATUS;
  wire addr_ok = hit_ctrl | hit_active | hit_meas | hit_status;
  wire wr_en = pclken & psel & penable & pwrite;
  wire [31:0] rd_mux =
    hit_ctrl ? {{(32 - `CTRL_W){1'b0}}, ctrl_q} :
    hit_active ? active_q :
    hit_meas ? {8'h00, meas_q} :
    hit_status ? status_w : 32'h0000_0000;

  // no wait states; a frozen clock enable stalls the bus
  assign pready = pclken;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_q;

  // writes land at the access edge, status is read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
      active_q <= `ACTIVE_RESET;
      meas_q <= 24'h00_0000;
      prdata_q <= 32'h0000_0000;
    end else if (pclken) begin
      if (psel && !penable) begin
        prdata_q <= rd_mux;
      end
      if (wr_en && hit_ctrl) begin
        ctrl_q <= pwdata[`CTRL_W-1:0];
      end
      if (wr_en && hit_active) begin
        active_q <= pwdata;
      end
      if (wr_en && hit_meas) begin
        meas_q <= pwdata[23:0];
      end
    end
  end

  wire cfg32 = ctrl_q[`CTL_CFG32];
  wire rec_mode = ctrl_q[`CTL_REC_MODE];
  wire cal_mode = ctrl_q[`CTL_CAL_MODE];
  wire mon_route = ctrl_q[`CTL_MON_ROUTE];
  wire rec_bus = ctrl_q[`CTL_REC_BUS];
  wire fm_bus = ctrl_q[`CTL_FM_BUS];
  wire dir_bus = ctrl_q[`CTL_DIR_BUS];

  // ***************************************************
  // channel selector
  // ***************************************************
  logic [4:0] chan_q; // selected channel minus one
  logic [4:0] chan_d;

  // walks the ring of fitted channels; stays if none is active
  function automatic logic [4:0] next_chan(input logic [4:0] cur,
    input logic [31:0] act, input logic big, input logic up);
    logic [5:0] top;
    logic [5:0] c;
    logic [4:0] res;
    logic found;
    top = big ? 6'd32 : 6'd16;
    c = {1'b0, cur};
    res = cur;
    found = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (up) begin
        c = (c >= top - 6'd1) ? 6'd0 : c + 6'd1;
      end else begin
        c = (c == 6'd0) ? top - 6'd1 : c - 6'd1;
      end
      if (!found && act[c[4:0]]) begin
        res = c[4:0];
        found = 1'b1;
      end
    end
    return res;
  endfunction

  always_comb begin
    chan_d = chan_q;
    if (!cfg32 && chan_q[4]) begin
      // configuration shrank under us
      chan_d = 5'd0;
    end else if (step_up) begin
      chan_d = next_chan(chan_q, active_q, cfg32, 1'b1);
    end else if (step_dn) begin
      chan_d = next_chan(chan_q, active_q, cfg32, 1'b0);
    end
  end

  wire [5:0] chan_num = {1'b0, chan_q} + 6'd1;
  wire [1:0] chan_tens = (chan_num >= 6'd30) ? 2'd3 : (chan_num >= 6'd20) ? 2'd2 :
                         (chan_num >= 6'd10) ? 2'd1 : 2'd0;
  wire [5:0] chan_ones = chan_num - ({4'h0, chan_tens} * 6'd10);

  // ***************************************************
  // card type, monitor card and buses
  // ***************************************************
  card_code_t shown_card; // card facing the meter
  logic mon_card_q; // monitor card picked in reproduce

  // record mode shows the record card, otherwise the play card
  assign shown_card = rec_mode ? rec_card_type : play_card_type;
  wire card_fm = (shown_card == CARD_MEDIUM) | (shown_card == CARD_WIDE);
  wire mismatch = rec_mode & (rec_card_type != play_card_type);
  wire card_on = mismatch ? blink_q : 1'b1;

  wire card_toggle = btn_press[`BTN_CARD] & mon_route & ~rec_mode;
  wire mon_card_w = rec_mode ? chan_q[0] : mon_card_q;

  // ***************************************************
  // meter function, source, stimulus, auto-test
  // ***************************************************
  meter_fn_t fn_q; // selected meter function
  meter_fn_t fn_d;
  logic ext_src_q; // calibration source is external
  logic [1:0] stim_q; // stimulus position, clockwise
  logic autotest_q; // auto-test running

  wire meter_ok = ctrl_q[`CTL_METER_OK];
  always_comb begin
    fn_d = fn_q;
    if (meter_ok && btn_press[`BTN_RIGHT]) begin
      fn_d = (fn_q == FN_DIST) ? FN_FREQ : meter_fn_t'(fn_q + 3'd1);
    end else if (meter_ok && btn_press[`BTN_LEFT]) begin
      fn_d = (fn_q == FN_FREQ) ? FN_DIST : meter_fn_t'(fn_q - 3'd1);
    end
  end

  wire src_toggle = ctrl_q[`CTL_SOURCE_OK] & btn_press[`BTN_SOURCE];
  wire stim_step = ctrl_q[`CTL_STIM_OK] & btn_press[`BTN_STIM];
  wire test_enter = btn_press[`BTN_TEST] & cal_mode;

  // selector state; leaving calibration ends auto-test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q <= 5'd0;
      mon_card_q <= 1'b0;
      fn_q <= FN_FREQ;
      ext_src_q <= 1'b0;
      stim_q <= 2'd0;
      autotest_q <= 1'b0;
    end else if (pclken) begin
      chan_q <= chan_d;
      fn_q <= fn_d;
      mon_card_q <= mon_card_q ^ card_toggle;
      ext_src_q <= ext_src_q ^ src_toggle;
      stim_q <= stim_q + {1'b0, stim_step};
      autotest_q <= cal_mode & (autotest_q | test_enter);
    end
  end

  // ***************************************************
  // lamps and readouts from flip-flops, except cal_lamp, which is gated from them
  // ***************************************************
  logic [24:0] lamp_d;
  logic [24:0] lamp_q;
  logic [31:0] digit_q; // channel then measurement digits

  wire fn_on = meter_source_switch ? blink_q : 1'b1;
  wire dir_on = ctrl_q[`CTL_PRE_TOP] ? blink_q : 1'b1;
  wire cal_on = (cal_mode | autotest_q) & (ctrl_q[`CTL_TEST_FAIL] ? blink_q : 1'b1);

  always_comb begin
    lamp_d[0] = card_on & (shown_card == CARD_DIRECT);
    lamp_d[1] = card_on & (shown_card == CARD_MEDIUM);
    lamp_d[2] = card_on & (shown_card == CARD_WIDE);
    lamp_d[3] = mon_route;
    lamp_d[4] = mon_card_w;
    lamp_d[5] = ~rec_bus;
    lamp_d[6] = rec_bus;
    lamp_d[7] = cal_mode & rec_mode & (fn_q == FN_FREQ) & rec_bus & card_fm;
    lamp_d[8] = fn_on & (fn_q == FN_FREQ);
    lamp_d[9] = fn_on & (fn_q == FN_DC);
    lamp_d[10] = fn_on & (fn_q == FN_PEAK);
    lamp_d[11] = fn_on & (fn_q == FN_RMS);
    lamp_d[12] = fn_on & (fn_q == FN_DIST);
    lamp_d[13] = ~ext_src_q;
    lamp_d[14] = ext_src_q;
    lamp_d[15] = stim_q == 2'd0;
    lamp_d[16] = stim_q == 2'd1;
    lamp_d[17] = stim_q == 2'd2;
    lamp_d[18] = stim_q == 2'd3;
    lamp_d[20:19] = stim_q;
    lamp_d[21] = card_fm;
    // sine or dc on both buses
    lamp_d[22] = fm_bus & (~dir_bus | card_fm);
    lamp_d[23] = dir_bus & dir_on;
    lamp_d[24] = fm_bus;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_q <= 25'h000_0000;
      digit_q <= 32'h0000_0000;
    end else if (pclken) begin
      lamp_q <= lamp_d;
      digit_q <= {2'b00, chan_tens, chan_ones[3:0], meas_q};
    end
  end

  assign status_w = {17'h0_0000, shown_card, mon_card_w, autotest_q, stim_q,
                     ext_src_q, fn_q, chan_q};
  assign channel_digits = digit_q[31:24];
  assign meas_digits = digit_q[23:0];
  assign direct_card_lamp = lamp_q[0];
  assign medium_band_card_lamp = lamp_q[1];
  assign wide_band_card_lamp = lamp_q[2];
  assign monitor_path_lamp = lamp_q[3];
  assign monitor_card_sel = lamp_q[4];
  assign play_bus_lamp = lamp_q[5];
  assign record_bus_lamp = lamp_q[6];
  assign bypass_bus_sel = lamp_q[7];
  assign frequency_function_lamp = lamp_q[8];
  assign dc_function_lamp = lamp_q[9];
  assign peak_function_lamp = lamp_q[10];
  assign rms_function_lamp = lamp_q[11];
  assign distortion_function_lamp = lamp_q[12];
  assign internal_source_lamp = lamp_q[13];
  assign external_source_lamp = lamp_q[14];
  assign stimulus_pos0_lamp = lamp_q[15];
  assign stimulus_pos1_lamp = lamp_q[16];
  assign stimulus_pos2_lamp = lamp_q[17];
  assign stimulus_pos3_lamp = lamp_q[18];
  assign stimulus_select = lamp_q[21:19];
  assign stimulus_dc_level = lamp_q[22];
  assign direct_bus_lamp = lamp_q[23];
  assign fm_bus_lamp = lamp_q[24];
  assign cal_lamp = cal_on;
  assign autotest_lamp = autotest_q;

  // ***************************************************
  // assertions
  // ***************************************************
  property p_up_wrap;
    @(posedge pclk) disable iff (!presetn)
    pclken && step_up && active_q[0] && (chan_q == (cfg32 ? 5'd31 : 5'd15))
    |=> chan_q == 5'd0;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up did not wrap");

  property p_dn_wrap;
    @(posedge pclk) disable iff (!presetn)
    pclken && step_dn && chan_q == 5'd0 && active_q[cfg32 ? 31 : 15]
    |=> chan_q == (cfg32 ? 5'd31 : 5'd15);
  endproperty
  a_dn_wrap: assert property (p_dn_wrap) else $error("down did not wrap");

  property p_card_onehot;
    @(posedge pclk) disable iff (!presetn)
    $onehot0({direct_card_lamp, medium_band_card_lamp, wide_band_card_lamp});
  endproperty
  a_card_onehot: assert property (p_card_onehot) else $error("two card lamps");

  property p_right;
    @(posedge pclk) disable iff (!presetn)
    pclken && meter_ok && btn_press[`BTN_RIGHT] && fn_q == FN_DIST
    |=> fn_q == FN_FREQ;
  endproperty
  a_right: assert property (p_right) else $error("right wrap wrong");

  property p_left;
    @(posedge pclk) disable iff (!presetn)
    pclken && meter_ok && btn_press[`BTN_LEFT] && !btn_press[`BTN_RIGHT]
    && fn_q == FN_DC |=> fn_q == FN_FREQ;
  endproperty
  a_left: assert property (p_left) else $error("left step wrong");

  property p_src;
    @(posedge pclk) disable iff (!presetn)
    pclken && src_toggle |=> ##1 external_source_lamp != $past(external_source_lamp, 2)
    && (internal_source_lamp ^ external_source_lamp);
  endproperty
  a_src: assert property (p_src) else $error("source not toggled");

  property p_stim;
    @(posedge pclk) disable iff (!presetn)
    pclken && stim_step && stim_q == 2'd3 |=> ##1 stimulus_pos0_lamp
    && $onehot({stimulus_pos3_lamp, stimulus_pos2_lamp, stimulus_pos1_lamp,
                stimulus_pos0_lamp});
  endproperty
  a_stim: assert property (p_stim) else $error("stimulus not rotated");

  property p_test_gate;
    @(posedge pclk) disable iff (!presetn)
    pclken && !cal_mode |=> !autotest_lamp;
  endproperty
  a_test_gate: assert property (p_test_gate) else $error("auto-test without cal");

  property p_cal_lamp;
    @(posedge pclk) disable iff (!presetn)
    pclken && test_enter && !wr_en && !ctrl_q[`CTL_TEST_FAIL] |=> autotest_lamp && cal_lamp;
  endproperty
  a_cal_lamp: assert property (p_cal_lamp) else $error("cal lamp dark");

endmodule // panel_chan_meter_cal

//--- panel_operator.sv
`timescale 1ns/1ps
// ****************************************
// operator model: pushbuttons and data cards
// ****************************************
module panel_operator (
  input wire logic pclk,
  output logic [7:0] buttons,
  output panel_sel_pkg::card_code_t rec_card,
  output panel_sel_pkg::card_code_t play_card
);
  import panel_sel_pkg::*;
  // idle panel: nothing pressed, direct cards fitted
  initial begin
    buttons = 8'h00;
    rec_card = CARD_DIRECT;
    play_card = CARD_DIRECT;
  end
  // a press is held n cycles; the release is left long enough to debounce too
  task automatic press(input int idx, input int n);
    @(posedge pclk);
    buttons[idx] <= 1'h1;
    repeat (n) @(posedge pclk);
    buttons[idx] <= 1'h0;
    repeat (12) @(posedge pclk);
  endtask
  // swap the record and reproduce cards of the channel
  task automatic cards(input card_code_t r, input card_code_t p);
    @(posedge pclk);
    rec_card <= r;
    play_card <= p;
  endtask
endmodule // panel_operator

//--- tb_top.sv
`timescale 1ns/1ps
`include "panel_sel_params.svh"
// ****************************************
// bench: apb master, reference counts, checks
// ****************************************
module tb_top;
  import panel_sel_pkg::*;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic meter_source_switch = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] ctl = 32'h0;
  logic [31:0] prdata, rd;
  logic [15:0] lf = 16'hcd32;
  logic [7:0] buttons, channel_digits;
  logic [23:0] meas_digits;
  logic [2:0] stimulus_select;
  card_code_t rec_card_type, play_card_type;
  logic pready, pslverr, err, direct_card_lamp, medium_band_card_lamp, wide_band_card_lamp;
  logic monitor_path_lamp, monitor_card_sel, play_bus_lamp, record_bus_lamp, bypass_bus_sel;
  logic frequency_function_lamp, dc_function_lamp, peak_function_lamp, rms_function_lamp;
  logic distortion_function_lamp, internal_source_lamp, external_source_lamp;
  logic stimulus_pos0_lamp, stimulus_pos1_lamp, stimulus_pos2_lamp, stimulus_pos3_lamp;
  logic stimulus_dc_level, direct_bus_lamp, fm_bus_lamp, cal_lamp, autotest_lamp;
  int fails = 0, n_tests = 0, cyc = 0, ch = 1, top = 16, fn = 0, pos = 0, hi, t;
  // lamp groups as one-hot vectors; watch gathers single lamps for count
  wire [4:0] fnl = {distortion_function_lamp, rms_function_lamp, peak_function_lamp,
    dc_function_lamp, frequency_function_lamp};
  wire [3:0] stl = {stimulus_pos3_lamp, stimulus_pos2_lamp, stimulus_pos1_lamp,
    stimulus_pos0_lamp};
  wire [2:0] cdl = {wide_band_card_lamp, medium_band_card_lamp, direct_card_lamp};
  wire [4:0] watch = {cal_lamp, direct_bus_lamp, |fnl, medium_band_card_lamp, direct_card_lamp};
  panel_operator panel_operator_inst (.pclk, .buttons, .rec_card(rec_card_type),
    .play_card(play_card_type));
  // short counts keep the run small: debounce 4, repeat 20, blink half period 8
  panel_chan_meter_cal #(.DEB_CYCLES(4), .RPT_CYCLES(20), .BLINK_CYCLES(8))
    panel_chan_meter_cal_inst (.pclk, .presetn, .pclken(1'h1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .buttons, .meter_source_switch,
    .rec_card_type, .play_card_type, .channel_digits, .meas_digits, .direct_card_lamp,
    .medium_band_card_lamp, .wide_band_card_lamp, .monitor_path_lamp, .monitor_card_sel,
    .play_bus_lamp, .record_bus_lamp, .bypass_bus_sel, .frequency_function_lamp,
    .dc_function_lamp, .peak_function_lamp, .rms_function_lamp, .distortion_function_lamp,
    .internal_source_lamp, .external_source_lamp, .stimulus_pos0_lamp, .stimulus_pos1_lamp,
    .stimulus_pos2_lamp, .stimulus_pos3_lamp, .stimulus_select, .stimulus_dc_level,
    .direct_bus_lamp, .fm_bus_lamp, .cal_lamp, .autotest_lamp);
  always #5 pclk = ~pclk;
  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // one apb transfer; the answer is taken only at the edge that sees pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wctl();
    apb(1'h1, `REG_CTRL, ctl);
    settle(3);
  endtask
  task automatic p(input int i);
    panel_operator_inst.press(i, 10);
  endtask
  // count cycles the watched lamp is lit: a blinking lamp is neither 0 nor 40
  task automatic count(input int k);
    settle(3);
    hi = 0;
    repeat (40) begin
      @(posedge pclk);
      #1;
      hi += watch[k];
    end
  endtask
  // step the channel and compare with the wrapping reference count
  task automatic chan(input int i);
    p(i);
    if (i == `BTN_UP) ch = (ch == top) ? 1 : ch + 1;
    else ch = (ch == 1) ? top : ch - 1;
    check(channel_digits, {4'(ch / 10), 4'(ch % 10)});
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    settle(3);
    check(channel_digits, 8'h01);
    check(fnl, 5'h01);
    check(stl, 4'h1);
    check(cdl, 3'h1);
    check({record_bus_lamp, play_bus_lamp}, 2'h1);
    apb(1'h0, 12'h010, 32'h0);
    check(err, 1'h1);
    chan(`BTN_DOWN);
    chan(`BTN_UP);
    ctl[`CTL_CFG32] = 1'h1;
    wctl();
    top = 32;
    chan(`BTN_DOWN);
    chan(`BTN_UP);
    for (int i = 0; i < 6; i++) chan(rnd() & 1);
    ctl[`CTL_MON_ROUTE] = 1'h1;
    wctl();
    check(monitor_path_lamp, 1'h1);
    for (int i = 1; i < 3; i++) begin
      p(`BTN_CARD);
      check(monitor_card_sel, i % 2);
    end
    ctl[`CTL_REC_MODE] = 1'h1;
    ctl[`CTL_REC_BUS] = 1'h1;
    wctl();
    p(`BTN_CARD);
    check(monitor_card_sel, (ch - 1) % 2);
    check({record_bus_lamp, play_bus_lamp}, 2'h2);
    panel_operator_inst.cards(CARD_DIRECT, CARD_WIDE);
    count(0);
    check(hi > 0 && hi < 40, 1);
    panel_operator_inst.cards(CARD_MEDIUM, CARD_MEDIUM);
    count(1);
    check(hi, 40);
    ctl[`CTL_CAL_MODE] = 1'h1;
    wctl();
    check(bypass_bus_sel, 1'h1);
    ctl[`CTL_CAL_MODE] = 1'h0;
    ctl[`CTL_REC_MODE] = 1'h0;
    wctl();
    for (int i = 0; i < 4; i++) begin
      t = rnd() % 3;
      panel_operator_inst.cards(CARD_DIRECT, card_code_t'(t));
      settle(3);
      check(cdl, 3'h1 << t);
    end
    p(`BTN_RIGHT);
    p(`BTN_SOURCE);
    check(fnl, 5'h01);
    check({external_source_lamp, internal_source_lamp}, 2'h1);
    ctl[`CTL_METER_OK] = 1'h1;
    ctl[`CTL_SOURCE_OK] = 1'h1;
    ctl[`CTL_STIM_OK] = 1'h1;
    wctl();
    p(`BTN_SOURCE);
    check({external_source_lamp, internal_source_lamp}, 2'h2);
    for (int i = 0; i < 8; i++) begin
      p(i > 4 ? `BTN_LEFT : `BTN_RIGHT);
      fn = (i > 4) ? (fn + 4) % 5 : (fn + 1) % 5;
      check(fnl, 5'h01 << fn);
    end
    meter_source_switch <= 1'h1;
    count(2);
    check(hi > 0 && hi < 40, 1);
    @(posedge pclk) meter_source_switch <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      t = rnd() % 3;
      panel_operator_inst.cards(CARD_DIRECT, card_code_t'(t));
      p(`BTN_STIM);
      pos = (pos + 1) % 4;
      check(stl, 4'h1 << pos);
      check(stimulus_select, {t != 0, pos[1:0]});
    end
    ctl[`CTL_FM_BUS] = 1'h1;
    ctl[`CTL_DIR_BUS] = 1'h1;
    wctl();
    check({fm_bus_lamp, direct_bus_lamp}, 2'h3);
    panel_operator_inst.cards(CARD_DIRECT, CARD_MEDIUM);
    settle(3);
    check(stimulus_dc_level, 1'h1);
    panel_operator_inst.cards(CARD_DIRECT, CARD_DIRECT);
    settle(3);
    check(stimulus_dc_level, 1'h0);
    ctl[`CTL_PRE_TOP] = 1'h1;
    wctl();
    count(3);
    check(hi > 0 && hi < 40, 1);
    p(`BTN_TEST);
    check(autotest_lamp, 1'h0);
    ctl[`CTL_CAL_MODE] = 1'h1;
    wctl();
    check(cal_lamp, 1'h1);
    p(`BTN_TEST);
    check(autotest_lamp, 1'h1);
    ctl[`CTL_TEST_FAIL] = 1'h1;
    wctl();
    count(4);
    check(hi > 0 && hi < 40, 1);
    @(posedge pclk) pwdata <= {rnd(), rnd()};
    settle(1);
    apb(1'h1, `REG_MEAS, pwdata);
    settle(3);
    check(meas_digits, pwdata[23:0]);
    panel_operator_inst.press(`BTN_UP, 66);
    apb(1'h0, `REG_STATUS, 32'h0);
    t = (32'(rd[4:0]) + 1 - ch + 32) % 32;
    check(t >= 2 && t <= 5, 1);
    wrap_up();
  end
endmodule // tb_top
